/* adc_seq_defines.vh */
// constants for the converter sequencing control block
// Behaviour
// - power-down bit 7 stops the converter
// - hold field gives 1 to 4 sample clocks
// - order bit picks result byte arrangement
// - clock select picks 24 or 12 MHz
// - channel field selects input 0 to 7
// - sample clock 6, 3, 2.4, 2 MHz
// - gain applies to channels 0,1 only
// - busy reads 1 during conversion
// - writing start bit begins conversion
// - engine converts channels 0 then 1 itself
// - phase sampling waits the sample delay
// - trigger bit picks counter max or min
// - automatic sampling raises converter interrupt
// - software results land in two data registers
// - phase current is sample plus offset
// - paged offsets share addresses, reset 0x200
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH
`define ADR_START 8'hc1
`define ADR_CONTROL 8'hc2
`define ADR_RES_LOW 8'hc3
`define ADR_RES_HIGH 8'hc4
`define ADR_DELAY 8'hc5
`define ADR_OFS_LOW 8'hc9
`define ADR_OFS_HIGH 8'hca
`define ADR_FIELD 8'hd6
`define RST_CONTROL 8'h80
`define RST_DELAY 8'h33
`define RST_OFFSET 10'h200
`define BIT_PD 7
`define BIT_ORDER 4
`define BIT_CKS 3
`define BIT_BUSY 3
`define BIT_START 0
`define BIT_TRIG 2
`define SYS_MHZ 100
`define CONV_CYCLES 5'd12
`define DIV_6MHZ 8'd16
`define DIV_3MHZ 8'd33
`define DIV_2P4MHZ 8'd41
`define DIV_2MHZ 8'd50
`endif

/* adc_seq_ctrl.v */
// converter sequencing control: registers, sample timing, auto phase sampling
`timescale 1ns/1ps
`include "adc_seq_defines.vh"
module adc_seq_ctrl #(
  parameter DW = 10
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  input wire register_page,
  input wire pwm_at_max,
  input wire pwm_at_min,
  input wire conv_done,
  input wire [DW-1:0] conv_data,
  output wire conv_power_down,
  output wire [2:0] conv_channel,
  output wire [1:0] amp_gain,
  output wire conv_clock_sel,
  output reg sample_clock,
  output reg conv_clock,
  output reg hold_active,
  output reg conv_strobe,
  output reg [DW-1:0] phase_a_current,
  output reg [DW-1:0] phase_b_current,
  output reg phase_valid,
  output reg conv_irq
);
  localparam IDLE = 3'd0;
  localparam DELAY = 3'd1;
  localparam HOLD = 3'd2;
  localparam CONV = 3'd3;
  localparam NEXT = 3'd4;

  reg rst_meta_ff, rst_sync_ff;
  wire rst_n = rst_sync_ff;
  // reset released through two flops
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // pwm extremes and converter handshakes come from other logic domains
  reg [2:0] sy1_ff, sy2_ff;
  reg [DW-1:0] data_m_ff;
  reg [DW-1:0] data_ff;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_ff <= 3'h0;
      sy2_ff <= 3'h0;
      data_m_ff <= {DW{1'b0}};
    end else begin
      sy1_ff <= {pwm_at_max, pwm_at_min, conv_done};
      sy2_ff <= sy1_ff;
      // data is only used once done has crossed, so it is steady by then
      data_m_ff <= conv_data;
    end
  end
  wire max_s = sy2_ff[2];
  wire min_s = sy2_ff[1];
  wire done_s = sy2_ff[0];
  reg max_d_ff, min_d_ff, done_d_ff;

  reg [7:0] start_ff;
  reg [7:0] control_ff;
  reg [7:0] delay_ff;
  reg [7:0] field_ff;
  reg [DW-1:0] ofs_a_ff, ofs_b_ff;
  reg [1:0] res_low_ff;
  reg [7:0] res_high_ff;
  reg busy_ff;
  reg [2:0] state_ff;
  reg auto_ff;
  reg chan_ff;
  reg [7:0] cnt_ff;
  reg [4:0] ccnt_ff;
  reg [7:0] sdiv_ff;
  reg cdiv_ff;
  reg [DW-1:0] samp_a_ff;
  reg sh_tick_ff;

  assign conv_power_down = control_ff[`BIT_PD];
  assign conv_clock_sel = control_ff[`BIT_CKS];
  // automatic pass owns channels 0 and 1
  assign conv_channel = auto_ff ? {2'b00, chan_ff} : control_ff[2:0];
  // gain is forced to x1 outside the phase channels
  assign amp_gain = (conv_channel[2:1] == 2'b00) ?
                    start_ff[5:4] : 2'b00;

  function [7:0] sh_div;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: sh_div = `DIV_6MHZ;
        2'b01: sh_div = `DIV_3MHZ;
        2'b10: sh_div = `DIV_2P4MHZ;
        default: sh_div = `DIV_2MHZ;
      endcase
    end
  endfunction

  // select constants are whole periods; the output toggles each half
  wire [7:0] sh_half = sh_div(start_ff[7:6]) >> 1;

  // sample clock divider; toggles twice per period from the select
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdiv_ff <= 8'h00;
      sample_clock <= 1'b0;
      sh_tick_ff <= 1'b0;
      cdiv_ff <= 1'b0;
      conv_clock <= 1'b0;
    end else begin
      sh_tick_ff <= 1'b0;
      if (sdiv_ff >= sh_half - 8'd1) begin
        sdiv_ff <= 8'h00;
        sample_clock <= ~sample_clock;
        sh_tick_ff <= sample_clock;
      end else begin
        sdiv_ff <= sdiv_ff + 8'd1;
      end
      // 12 MHz halves the 24 MHz enable; approximate ratio of core clock
      cdiv_ff <= ~cdiv_ff;
      conv_clock <= conv_clock_sel ? (cdiv_ff & ~conv_clock) : 1'b1;
    end
  end

  wire wr_start = sfr_wr && sfr_addr == `ADR_START &&
                  sfr_wdata[`BIT_START];
  wire trig = field_ff[`BIT_TRIG] ? (min_s & ~min_d_ff) :
              (max_s & ~max_d_ff);

  // conversion sequencer: software requests and engine phase passes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= IDLE;
      auto_ff <= 1'b0;
      chan_ff <= 1'b0;
      cnt_ff <= 8'h00;
      ccnt_ff <= 5'd0;
      busy_ff <= 1'b0;
      hold_active <= 1'b0;
      conv_strobe <= 1'b0;
      res_low_ff <= 2'b00;
      res_high_ff <= 8'h00;
      samp_a_ff <= {DW{1'b0}};
      phase_a_current <= {DW{1'b0}};
      phase_b_current <= {DW{1'b0}};
      phase_valid <= 1'b0;
      conv_irq <= 1'b0;
      max_d_ff <= 1'b0;
      min_d_ff <= 1'b0;
      done_d_ff <= 1'b0;
      data_ff <= {DW{1'b0}};
    end else begin
      max_d_ff <= max_s;
      min_d_ff <= min_s;
      done_d_ff <= done_s;
      data_ff <= data_m_ff;
      conv_strobe <= 1'b0;
      phase_valid <= 1'b0;
      conv_irq <= 1'b0;
      case (state_ff)
        IDLE: begin
          if (!conv_power_down && trig) begin
            auto_ff <= 1'b1;
            chan_ff <= 1'b0;
            cnt_ff <= delay_ff;
            state_ff <= DELAY;
          end else if (!conv_power_down && wr_start) begin
            auto_ff <= 1'b0;
            busy_ff <= 1'b1;
            ccnt_ff <= {3'b000, control_ff[6:5]};
            hold_active <= 1'b1;
            state_ff <= HOLD;
          end
        end
        DELAY: begin
          // spikes settle before the first phase is held
          if (cnt_ff == 8'h00) begin
            busy_ff <= 1'b1;
            ccnt_ff <= {3'b000, control_ff[6:5]};
            hold_active <= 1'b1;
            state_ff <= HOLD;
          end else begin
            cnt_ff <= cnt_ff - 8'd1;
          end
        end
        HOLD: begin
          if (sh_tick_ff) begin
            if (ccnt_ff == 5'd0) begin
              hold_active <= 1'b0;
              conv_strobe <= 1'b1;
              ccnt_ff <= `CONV_CYCLES;
              state_ff <= CONV;
            end else begin
              ccnt_ff <= ccnt_ff - 5'd1;
            end
          end
        end
        CONV: begin
          // result edge from the converter closes the conversion
          if (done_s & ~done_d_ff) begin
            if (auto_ff && !chan_ff) begin
              samp_a_ff <= data_ff;
              chan_ff <= 1'b1;
              state_ff <= NEXT;
            end else if (auto_ff) begin
              phase_a_current <= samp_a_ff + ofs_a_ff;
              phase_b_current <= data_ff + ofs_b_ff;
              phase_valid <= 1'b1;
              conv_irq <= 1'b1;
              busy_ff <= 1'b0;
              auto_ff <= 1'b0;
              state_ff <= IDLE;
            end else begin
              {res_high_ff, res_low_ff} <= data_ff;
              busy_ff <= 1'b0;
              state_ff <= IDLE;
            end
          end
        end
        NEXT: begin
          // channel 1 follows channel 0 with no further delay
          ccnt_ff <= {3'b000, control_ff[6:5]};
          hold_active <= 1'b1;
          state_ff <= HOLD;
        end
        default: state_ff <= IDLE;
      endcase
    end
  end

  // register writes; offsets paged on the shared addresses
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_ff <= 8'h00;
      control_ff <= `RST_CONTROL;
      delay_ff <= `RST_DELAY;
      field_ff <= 8'h00;
      ofs_a_ff <= `RST_OFFSET;
      ofs_b_ff <= `RST_OFFSET;
    end else if (sfr_wr) begin
      case (sfr_addr)
        `ADR_START: start_ff <= {sfr_wdata[7:4], 4'h0};
        `ADR_CONTROL: control_ff <= sfr_wdata;
        `ADR_DELAY: delay_ff <= sfr_wdata;
        `ADR_FIELD: field_ff <= sfr_wdata;
        `ADR_OFS_LOW: begin
          if (register_page) ofs_b_ff[7:0] <= sfr_wdata;
          else ofs_a_ff[7:0] <= sfr_wdata;
        end
        `ADR_OFS_HIGH: begin
          if (register_page) ofs_b_ff[9:8] <= sfr_wdata[1:0];
          else ofs_a_ff[9:8] <= sfr_wdata[1:0];
        end
        default: start_ff <= start_ff;
      endcase
    end
  end

  // read data; order bit swaps which byte carries the top bits
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `ADR_START: sfr_rdata <= {start_ff[7:4], busy_ff, 3'b000};
        `ADR_CONTROL: sfr_rdata <= control_ff;
        `ADR_RES_LOW: sfr_rdata <= control_ff[`BIT_ORDER] ?
          {6'h00, res_high_ff[7:6]} : {6'h00, res_low_ff};
        `ADR_RES_HIGH: sfr_rdata <= control_ff[`BIT_ORDER] ?
          {res_high_ff[5:0], res_low_ff} : res_high_ff;
        `ADR_FIELD: sfr_rdata <= field_ff;
        `ADR_OFS_LOW: sfr_rdata <= register_page ?
          ofs_b_ff[7:0] : ofs_a_ff[7:0];
        `ADR_OFS_HIGH: sfr_rdata <= {6'h00, register_page ?
          ofs_b_ff[9:8] : ofs_a_ff[9:8]};
        default: sfr_rdata <= 8'h00; // delay register is write only
      endcase
    end
  end
endmodule // adc_seq_ctrl

/* adc_seq_ctrl_asserts.sv */
// port assertions for the converter sequencing control
`timescale 1ns/1ps
module adc_seq_ctrl_asserts (
  input wire sys_clk,
  input wire reset_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire conv_power_down,
  input wire [2:0] conv_channel,
  input wire [1:0] amp_gain,
  input wire conv_clock_sel,
  input wire hold_active,
  input wire conv_strobe,
  input wire phase_valid,
  input wire conv_irq
);
  // one clock domain, so clock and reset are given once
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  a_irq_valid: assert property (conv_irq |-> phase_valid)
    else $error("irq without phase result");
  a_irq_pulse: assert property (conv_irq |=> !conv_irq)
    else $error("irq longer than one cycle");
  a_gain_fixed: assert property (
    conv_channel > 3'h1 |-> amp_gain == 2'h0)
    else $error("gain not unity on a plain channel");
  a_pd_quiet: assert property (conv_power_down |-> !conv_strobe)
    else $error("conversion while powered down");
  a_ctrl_write: assert property (
    sfr_wr && sfr_addr == 8'hc2 |=>
    conv_power_down == $past(sfr_wdata[7]) &&
    conv_clock_sel == $past(sfr_wdata[3]) &&
    conv_channel == $past(sfr_wdata[2:0]))
    else $error("control fields not taken from write");
  a_hold_first: assert property (conv_strobe |-> $past(hold_active))
    else $error("conversion without hold phase");
  a_strobe_pulse: assert property (conv_strobe |=> !conv_strobe)
    else $error("start strobe longer than one cycle");
  a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
endmodule // adc_seq_ctrl_asserts

bind adc_seq_ctrl adc_seq_ctrl_asserts chk (.sys_clk, .reset_n,
  .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .conv_power_down,
  .conv_channel, .amp_gain, .conv_clock_sel, .hold_active, .conv_strobe,
  .phase_valid, .conv_irq);

/* conv_model.sv */
// behavioural converter core answering each start strobe
`timescale 1ns/1ps
module conv_model (
  input wire sys_clk,
  input wire conv_strobe,
  input wire [7:0] lag,
  output reg conv_done,
  output reg [9:0] conv_data,
  output reg [7:0] served
);
  reg [8:0] cnt_ff;
  initial begin
    conv_done = 1'b0;
    conv_data = 10'h2aa;
    served = 8'h00;
    cnt_ff = 9'h1ff;
  end
  // data counts up per result so a swapped phase order shows
  always @(posedge sys_clk) begin
    if (conv_strobe) begin
      conv_done <= 1'b0;
      cnt_ff <= {1'b0, lag};
    end else if (cnt_ff == 9'h000) begin
      conv_done <= 1'b1;
      conv_data <= {2'b01, served};
      served <= served + 8'h01;
      cnt_ff <= 9'h1ff;
    end else if (!cnt_ff[8]) begin
      cnt_ff <= cnt_ff - 9'h001;
      conv_data <= ~conv_data; // not valid until done rises
    end
  end
endmodule // conv_model

/* adc_sequencing_control_tb.sv */
// self-checking bench for the converter sequencing control
`timescale 1ns/1ps
module adc_sequencing_control_tb;
  reg sys_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [7:0] sfr_addr = 8'h00;
  reg sfr_wr = 1'b0;
  reg sfr_rd = 1'b0;
  reg [7:0] sfr_wdata = 8'h00;
  reg register_page = 1'b0;
  reg pwm_at_max = 1'b0;
  reg pwm_at_min = 1'b0;
  reg [7:0] lag = 8'h05;
  wire [7:0] sfr_rdata, served;
  wire [9:0] conv_data, phase_a_current, phase_b_current;
  wire [2:0] conv_channel;
  wire [1:0] amp_gain;
  wire conv_done, conv_power_down, conv_clock_sel, conv_strobe;
  wire phase_valid, conv_irq, sample_clock;
  integer bad_count = 0;
  integer n_compared = 0;
  integer na;
  reg [7:0] v;
  reg [7:0] s;
  always #5 sys_clk = ~sys_clk;
  adc_seq_ctrl DUT (.sys_clk, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .register_page, .pwm_at_max, .pwm_at_min,
    .conv_done, .conv_data, .conv_power_down, .conv_channel, .amp_gain,
    .conv_clock_sel, .sample_clock, .conv_clock(), .hold_active(),
    .conv_strobe, .phase_a_current, .phase_b_current, .phase_valid,
    .conv_irq);
  conv_model M (.sys_clk, .conv_strobe, .lag, .conv_done, .conv_data,
    .served);
  task conclude;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task check(input [47:0] nm, input [9:0] e, input [9:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task bound(input integer n, input integer lim);
    begin
      if (n >= lim) begin
        bad_count = bad_count + 1;
        $display("MISMATCH wait exp done got timeout");
        conclude;
      end
    end
  endtask
  // each access leaves an idle edge so strobes never retrigger at once
  task wr(input [7:0] a, input [7:0] d);
    begin
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge sys_clk) #1;
      sfr_wr = 1'b0;
      @(posedge sys_clk) #1;
    end
  endtask
  task rd(input [7:0] a);
    begin
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge sys_clk) #1;
      sfr_rd = 1'b0;
      @(posedge sys_clk) #1;
      v = sfr_rdata;
    end
  endtask
  task rdchk(input [7:0] a, input [7:0] e, input [47:0] nm);
    begin
      rd(a);
      check(nm, e, v);
    end
  endtask
  task t_reset;
    begin
      rdchk(8'hc2, 8'h80, "ctl0");
      rdchk(8'hc1, 8'h00, "str0");
      rdchk(8'hc9, 8'h00, "ofl0");
      rdchk(8'hca, 8'h02, "ofh0");
    end
  endtask
  task t_regs;
    begin
      wr(8'hc1, 8'h30);
      wr(8'hc2, 8'h0a);
      check("pd", 10'h0, conv_power_down);
      check("cks", 10'h1, conv_clock_sel);
      check("ch", 10'h2, conv_channel);
      check("gain2", 10'h0, amp_gain);
      rdchk(8'hc2, 8'h0a, "ctl");
      wr(8'hc2, 8'h01);
      check("gain1", 10'h3, amp_gain);
    end
  endtask
  // rising edges of the sample clock over 160 core cycles
  task t_sclk(input [7:0] sel, input integer lo, input integer hi);
    integer r;
    reg q;
    begin
      wr(8'hc1, sel);
      r = 0;
      q = sample_clock;
      repeat (160) begin
        @(posedge sys_clk) #1;
        if (sample_clock === 1'b1 && q === 1'b0) r = r + 1;
        q = sample_clock;
      end
      check("sample_clock", 10'h1, r >= lo && r <= hi);
    end
  endtask
  // a start while powered down is refused
  task t_pd;
    begin
      wr(8'hc2, 8'h83);
      check("pd1", 10'h1, conv_power_down);
      wr(8'hc1, 8'h01);
      rd(8'hc1);
      check("pdbusy", 10'h0, v[3]);
    end
  endtask
  task t_offsets;
    begin
      wr(8'hc9, 8'h10);
      wr(8'hca, 8'h00);
      register_page = 1'b1;
      rdchk(8'hca, 8'h02, "ofhb");
      wr(8'hc9, 8'hf0);
      wr(8'hca, 8'h03);
      rdchk(8'hc9, 8'hf0, "oflb");
      register_page = 1'b0;
      rdchk(8'hc9, 8'h10, "ofla");
    end
  endtask
  // the wrong counter end is raised first and must start nothing
  task t_auto(input mn, input [7:0] dly);
    integer n;
    begin
      wr(8'hc5, dly);
      wr(8'hd6, {5'h00, mn, 2'h0});
      pwm_at_min = !mn;
      pwm_at_max = mn;
      n = 0;
      repeat (400) begin
        @(posedge sys_clk) #1;
        if (conv_irq === 1'b1) n = n + 1;
      end
      check("wrong", 10'h0, n);
      s = served;
      pwm_at_min = mn;
      pwm_at_max = !mn;
      n = 0;
      while (conv_irq !== 1'b1 && n < 3000) begin
        @(posedge sys_clk) #1;
        n = n + 1;
      end
      bound(n, 3000);
      if (mn) check("delay", 10'h1, n - na > 190);
      na = n;
      check("ia", {2'b01, s} + 10'h010, phase_a_current);
      check("ib", {2'b01, s + 8'h01} + 10'h3f0, phase_b_current);
      check("valid", 10'h1, phase_valid);
      pwm_at_min = 1'b0;
      pwm_at_max = 1'b0;
    end
  endtask
  task t_soft(input ord);
    reg [9:0] d;
    integer n;
    begin
      lag = 8'h28;
      wr(8'hc2, {3'h0, ord, 4'h3});
      s = served;
      wr(8'hc1, 8'h01);
      rd(8'hc1);
      check("busy", 10'h1, v[3]);
      n = 0;
      while (v[3] !== 1'b0 && n < 200) begin
        rd(8'hc1);
        n = n + 1;
      end
      bound(n, 200);
      d = {2'b01, s};
      rdchk(8'hc4, ord ? d[7:0] : d[9:2], "hi");
      rdchk(8'hc3, ord ? d[9:8] : d[1:0], "lo");
    end
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge sys_clk) #1;
    t_reset;
    t_regs;
    t_sclk(8'hf0, 3, 4);
    t_sclk(8'h30, 9, 11);
    t_offsets;
    t_auto(1'b0, 8'h04);
    t_auto(1'b1, 8'hf0);
    t_soft(1'b0);
    t_soft(1'b1);
    t_pd;
    conclude;
  end
endmodule // adc_sequencing_control_tb
